// ### lpp_phy.sv
// low-rate pan phy: framing, energy scan and clear channel assessment
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lpp_consts.svh"

module lpp_phy #(
  parameter int SYM_CYC = `LPP_SYM_CYC,
  parameter int WIN_SYMS = `LPP_WIN_SYMS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire lpp_pkg::lpp_bus_req_t bus_i,
  output logic [31:0] bus_rdata_o,
  // frame buffer memory
  output lpp_pkg::lpp_mem_req_t mem_o,
  input wire logic [7:0] mem_rdata_i,
  // transmit octet stream
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // receive octet stream and signal strength
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic [7:0] rssi_i,
  // events and radio setting
  output lpp_pkg::lpp_events_t event_o,
  output logic [6:0] freq_setting_o
);

  localparam int WIN_LG = $clog2(WIN_SYMS);

  generate
    if (SYM_CYC < 2 || SYM_CYC > 65535 || WIN_SYMS < 1 || WIN_SYMS > 8 || (WIN_SYMS & (WIN_SYMS - 1)) != 0) begin : g_bad
      $error("lpp_phy: unsupported SYM_CYC or WIN_SYMS");
    end
  endgenerate

  localparam lpp_pkg::lpp_state_t ST_RST = '{sfd: `LPP_SFD_RST, seed: `LPP_SEED_RST, default: '0};

  function automatic logic [15:0] lpp_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `LPP_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  lpp_pkg::lpp_state_t st_r;
  lpp_pkg::lpp_state_t st_nxt;
  lpp_pkg::lpp_tx_st_t tx_st_r;
  lpp_pkg::lpp_tx_st_t tx_st_nxt;
  lpp_pkg::lpp_rx_st_t rx_st_r;
  lpp_pkg::lpp_rx_st_t rx_st_nxt;
  lpp_pkg::lpp_ms_st_t ms_r;
  lpp_pkg::lpp_ms_st_t ms_nxt;

  logic [3:0] tsk;
  logic take;
  logic tick;
  logic [10:0] acc_sum;
  logic [7:0] avg;
  logic [7:0] maxn;
  logic [7:0] lvl;
  logic ed_busy;
  logic cs_busy;
  logic busy;
  logic [7:0] len_eff;
  logic [7:0] idx_n;
  logic [15:0] crc_n;

  always_comb begin
    st_nxt = st_r;
    tx_st_nxt = tx_st_r;
    rx_st_nxt = rx_st_r;
    ms_nxt = ms_r;
    st_nxt.ev = '0;
    st_nxt.mem = '0;
    st_nxt.rdata = 32'h0000_0000;
    tsk = 4'h0;
    lvl = 8'h00;
    ed_busy = 1'b0;
    cs_busy = 1'b0;
    busy = 1'b0;
    len_eff = 8'h00;
    idx_n = 8'h00;
    crc_n = 16'h0000;
    take = !st_r.tx_valid || tx_ready_i;
    tick = st_r.sym_cnt == 16'(SYM_CYC - 1);
    acc_sum = st_r.acc + {3'h0, rssi_i};
    avg = 8'(acc_sum >> WIN_LG);
    maxn = (avg > st_r.maxv) ? avg : st_r.maxv;

    // register writes and tasks
    if (bus_i.we) begin
      if (bus_i.addr == `LPP_OFF_TASK) begin
        tsk = st_r.ctrl.phy_en ? bus_i.wdata[3:0] : 4'h0;
      end else if (bus_i.addr == `LPP_OFF_CTRL) begin
        st_nxt.ctrl = bus_i.wdata[4:0];
      end else if (bus_i.addr == `LPP_OFF_SFD) begin
        st_nxt.sfd = bus_i.wdata[7:0];
      end else if (bus_i.addr == `LPP_OFF_PTR) begin
        st_nxt.ptr = bus_i.wdata[15:0];
      end else if (bus_i.addr == `LPP_OFF_ENERGY_SCAN_REPEAT_COUNT) begin
        st_nxt.ed_cnt = bus_i.wdata[7:0];
      end else if (bus_i.addr == `LPP_OFF_THR) begin
        st_nxt.thr = bus_i.wdata[7:0];
      end else if (bus_i.addr == `LPP_OFF_FREQ) begin
        st_nxt.freq = bus_i.wdata[6:0];
      end else if (bus_i.addr == `LPP_OFF_SEED) begin
        st_nxt.seed = bus_i.wdata[15:0];
      end
    end

    // register reads, answered next cycle
    if (bus_i.re) begin
      if (bus_i.addr == `LPP_OFF_CTRL) begin
        st_nxt.rdata = {27'h0, st_r.ctrl};
      end else if (bus_i.addr == `LPP_OFF_SFD) begin
        st_nxt.rdata = {24'h0, st_r.sfd};
      end else if (bus_i.addr == `LPP_OFF_PTR) begin
        st_nxt.rdata = {16'h0, st_r.ptr};
      end else if (bus_i.addr == `LPP_OFF_ENERGY_SCAN_REPEAT_COUNT) begin
        st_nxt.rdata = {24'h0, st_r.ed_cnt};
      end else if (bus_i.addr == `LPP_OFF_THR) begin
        st_nxt.rdata = {24'h0, st_r.thr};
      end else if (bus_i.addr == `LPP_OFF_LEVEL) begin
        st_nxt.rdata = {24'h0, st_r.level};
      end else if (bus_i.addr == `LPP_OFF_STATUS) begin
        st_nxt.rdata = {st_r.fcf, st_r.phr, 4'h0, rx_st_r != lpp_pkg::LPP_RX_HUNT,
                        tx_st_r != lpp_pkg::LPP_TX_IDLE, ms_r != lpp_pkg::LPP_MS_IDLE, st_r.crc_ok};
      end else if (bus_i.addr == `LPP_OFF_FREQ) begin
        st_nxt.rdata = {25'h0, st_r.freq};
      end else if (bus_i.addr == `LPP_OFF_SEED) begin
        st_nxt.rdata = {16'h0, st_r.seed};
      end
    end

    // transmit framer
    if (st_r.tx_valid && tx_ready_i) begin
      st_nxt.tx_valid = 1'b0;
    end
    case (tx_st_r)
      lpp_pkg::LPP_TX_IDLE: begin
        if (tsk[`LPP_TASK_TX] && rx_st_r == lpp_pkg::LPP_RX_HUNT) begin
          st_nxt.tx_cnt = 3'h0;
          tx_st_nxt = lpp_pkg::LPP_TX_PRE;
        end
      end
      lpp_pkg::LPP_TX_PRE: begin
        if (take) begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_data = `LPP_PRE_VALUE;
          st_nxt.tx_cnt = st_r.tx_cnt + 3'h1;
          if (st_r.tx_cnt == `LPP_PRE_OCTETS - 3'h1) begin
            tx_st_nxt = lpp_pkg::LPP_TX_SFD;
          end
        end
      end
      lpp_pkg::LPP_TX_SFD: begin
        if (take) begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_data = st_r.sfd;
          st_nxt.tx_idx = 8'h00;
          st_nxt.tx_crc = st_r.seed;
          tx_st_nxt = lpp_pkg::LPP_TX_FETCH;
        end
      end
      lpp_pkg::LPP_TX_FETCH: begin
        st_nxt.mem.re = 1'b1;
        st_nxt.mem.addr = st_r.ptr + {8'h00, st_r.tx_idx};
        tx_st_nxt = lpp_pkg::LPP_TX_WAIT;
      end
      lpp_pkg::LPP_TX_WAIT: begin
        tx_st_nxt = lpp_pkg::LPP_TX_LOAD;
      end
      lpp_pkg::LPP_TX_LOAD: begin
        st_nxt.tx_hold = mem_rdata_i;
        tx_st_nxt = lpp_pkg::LPP_TX_PUSH;
      end
      lpp_pkg::LPP_TX_PUSH: begin
        if (take) begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_data = st_r.tx_hold;
          if (st_r.tx_idx == 8'h00) begin
            st_nxt.tx_len = st_r.tx_hold[6:0];
            len_eff = {1'b0, st_r.tx_hold[6:0]};
          end else begin
            st_nxt.tx_crc = lpp_crc_byte(st_r.tx_crc, st_r.tx_hold);
            len_eff = {1'b0, st_r.tx_len};
          end
          idx_n = st_r.tx_idx + 8'h01;
          st_nxt.tx_idx = idx_n;
          if (idx_n == len_eff + 8'h01) begin
            tx_st_nxt = lpp_pkg::LPP_TX_DONE;
          end else if (st_r.ctrl.crc_en && len_eff >= `LPP_FCS_OCTETS && idx_n - 8'h01 == len_eff - `LPP_FCS_OCTETS) begin
            st_nxt.tx_cnt = 3'h0;
            tx_st_nxt = lpp_pkg::LPP_TX_CRC;
          end else begin
            tx_st_nxt = lpp_pkg::LPP_TX_FETCH;
          end
        end
      end
      lpp_pkg::LPP_TX_CRC: begin
        if (take) begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_data = (st_r.tx_cnt == 3'h0) ? st_r.tx_crc[7:0] : st_r.tx_crc[15:8];
          st_nxt.tx_cnt = st_r.tx_cnt + 3'h1;
          if (st_r.tx_cnt == 3'h1) begin
            tx_st_nxt = lpp_pkg::LPP_TX_DONE;
          end
        end
      end
      default: begin
        if (take) begin
          st_nxt.ev.frame_end = 1'b1;
          tx_st_nxt = lpp_pkg::LPP_TX_IDLE;
        end
      end
    endcase

    // receive deframer
    case (rx_st_r)
      lpp_pkg::LPP_RX_HUNT: begin
        if (rx_valid_i && st_r.ctrl.phy_en && tx_st_r == lpp_pkg::LPP_TX_IDLE && rx_data_i == st_r.sfd) begin
          rx_st_nxt = lpp_pkg::LPP_RX_PHR;
          if (ms_r == lpp_pkg::LPP_MS_CCA) begin
            st_nxt.cs_seen = 1'b1;
          end
        end
      end
      lpp_pkg::LPP_RX_PHR: begin
        if (rx_valid_i) begin
          if (rx_data_i[6:0] == 7'h00) begin
            rx_st_nxt = lpp_pkg::LPP_RX_HUNT;
          end else begin
            st_nxt.phr = rx_data_i;
            st_nxt.rx_len = rx_data_i[6:0];
            st_nxt.mem.we = 1'b1;
            st_nxt.mem.addr = st_r.ptr;
            st_nxt.mem.wdata = rx_data_i;
            st_nxt.ev.frame_begin = 1'b1;
            st_nxt.rx_crc = st_r.seed;
            st_nxt.rx_idx = 8'h01;
            rx_st_nxt = lpp_pkg::LPP_RX_DATA;
          end
        end
      end
      default: begin
        if (rx_valid_i) begin
          crc_n = lpp_crc_byte(st_r.rx_crc, rx_data_i);
          st_nxt.rx_crc = crc_n;
          if (st_r.rx_idx == 8'h01) begin
            st_nxt.fcf[7:0] = rx_data_i;
          end else if (st_r.rx_idx == 8'h02) begin
            st_nxt.fcf[15:8] = rx_data_i;
          end
          if (!(st_r.ctrl.crc_en && {1'b0, st_r.rx_len} < st_r.rx_idx + `LPP_FCS_OCTETS)) begin
            st_nxt.mem.we = 1'b1;
            st_nxt.mem.addr = st_r.ptr + {8'h00, st_r.rx_idx};
            st_nxt.mem.wdata = rx_data_i;
          end
          st_nxt.rx_idx = st_r.rx_idx + 8'h01;
          if (st_r.rx_idx == {1'b0, st_r.rx_len}) begin
            st_nxt.crc_ok = crc_n == 16'h0000;
            st_nxt.ev.frame_end = 1'b1;
            rx_st_nxt = lpp_pkg::LPP_RX_HUNT;
          end
        end
      end
    endcase

    // energy scan and channel assessment
    case (ms_r)
      lpp_pkg::LPP_MS_IDLE: begin
        if (tsk[`LPP_TASK_ED_START] || tsk[`LPP_TASK_CCA_START]) begin
          st_nxt.sym_cnt = 16'h0000;
          st_nxt.win_cnt = 4'h0;
          st_nxt.acc = 11'h000;
          st_nxt.maxv = 8'h00;
          st_nxt.iter = 8'h00;
          st_nxt.cs_seen = 1'b0;
          ms_nxt = tsk[`LPP_TASK_ED_START] ? lpp_pkg::LPP_MS_ED : lpp_pkg::LPP_MS_CCA;
        end
      end
      default: begin
        st_nxt.sym_cnt = st_r.sym_cnt + 16'h0001;
        if (tick) begin
          st_nxt.sym_cnt = 16'h0000;
          st_nxt.acc = acc_sum;
          st_nxt.win_cnt = st_r.win_cnt + 4'h1;
          if (st_r.win_cnt == 4'h0) begin
            st_nxt.first = rssi_i;
          end
          if (st_r.win_cnt == 4'(WIN_SYMS - 1)) begin
            st_nxt.acc = 11'h000;
            st_nxt.win_cnt = 4'h0;
            if (ms_r == lpp_pkg::LPP_MS_ED) begin
              if (st_r.ed_cnt == 8'h00) begin
                st_nxt.level = avg;
                st_nxt.ev.ed_done = 1'b1;
                ms_nxt = lpp_pkg::LPP_MS_IDLE;
              end else if (st_r.iter + 8'h01 == st_r.ed_cnt) begin
                st_nxt.level = maxn;
                st_nxt.ev.ed_done = 1'b1;
                ms_nxt = lpp_pkg::LPP_MS_IDLE;
              end else begin
                st_nxt.maxv = maxn;
                st_nxt.iter = st_r.iter + 8'h01;
              end
            end else begin
              lvl = (st_r.ctrl.cca_mode == lpp_pkg::LPP_CCA_TEST1) ? ((WIN_SYMS == 1) ? rssi_i : st_r.first) : avg;
              ed_busy = lvl >= st_r.thr;
              cs_busy = st_r.cs_seen || rx_st_r != lpp_pkg::LPP_RX_HUNT;
              if (st_r.ctrl.cca_mode == lpp_pkg::LPP_CCA_CARRIER) begin
                busy = cs_busy;
              end else if (st_r.ctrl.cca_mode == lpp_pkg::LPP_CCA_AND) begin
                busy = ed_busy && cs_busy;
              end else if (st_r.ctrl.cca_mode == lpp_pkg::LPP_CCA_OR) begin
                busy = ed_busy || cs_busy;
              end else begin
                busy = ed_busy;
              end
              st_nxt.level = lvl;
              st_nxt.ev.busy = busy;
              st_nxt.ev.clear = !busy;
              ms_nxt = lpp_pkg::LPP_MS_IDLE;
            end
          end
        end
      end
    endcase
    if (tsk[`LPP_TASK_ED_STOP]) begin
      st_nxt.ev.ed_halted = 1'b1;
      st_nxt.ev.ed_done = 1'b0;
      if (ms_r == lpp_pkg::LPP_MS_ED) begin
        ms_nxt = lpp_pkg::LPP_MS_IDLE;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= ST_RST;
      tx_st_r <= lpp_pkg::LPP_TX_IDLE;
      rx_st_r <= lpp_pkg::LPP_RX_HUNT;
      ms_r <= lpp_pkg::LPP_MS_IDLE;
    end else begin
      st_r <= st_nxt;
      tx_st_r <= tx_st_nxt;
      rx_st_r <= rx_st_nxt;
      ms_r <= ms_nxt;
    end
  end

  assign bus_rdata_o = st_r.rdata;
  assign mem_o = st_r.mem;
  assign tx_valid_o = st_r.tx_valid;
  assign tx_data_o = st_r.tx_data;
  assign event_o = st_r.ev;
  assign freq_setting_o = st_r.freq;

  // cycles since a measurement began, checks only
  logic [19:0] age_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      age_r <= 20'h00000;
    end else begin
      age_r <= (ms_r == lpp_pkg::LPP_MS_IDLE) ? 20'h00000 : age_r + 20'h00001;
    end
  end

  property p_pre_zero;
    @(posedge clk_i) disable iff (rst_i) (tx_st_r == lpp_pkg::LPP_TX_PRE && take) |=> (tx_valid_o && tx_data_o == 8'h00);
  endproperty
  a_pre_zero: assert property (p_pre_zero) else $error("preamble octet not zero");

  property p_sfd_sent;
    @(posedge clk_i) disable iff (rst_i) (tx_st_r == lpp_pkg::LPP_TX_SFD && take) |=> (tx_data_o == $past(st_r.sfd));
  endproperty
  a_sfd_sent: assert property (p_sfd_sent) else $error("delimiter octet wrong");

  property p_zero_drop;
    @(posedge clk_i) disable iff (rst_i)
      (rx_st_r == lpp_pkg::LPP_RX_PHR && rx_valid_i && rx_data_i[6:0] == 7'h00) |=> (!event_o.frame_begin && rx_st_r == lpp_pkg::LPP_RX_HUNT);
  endproperty
  a_zero_drop: assert property (p_zero_drop) else $error("zero length frame not dropped");

  property p_fcs_kept;
    @(posedge clk_i) disable iff (rst_i)
      (rx_st_r == lpp_pkg::LPP_RX_DATA && rx_valid_i && st_r.ctrl.crc_en && {1'b0, st_r.rx_len} < st_r.rx_idx + 8'h02) |=> !mem_o.we;
  endproperty
  a_fcs_kept: assert property (p_fcs_kept) else $error("checksum octet written to buffer");

  property p_verdict_time;
    @(posedge clk_i) disable iff (rst_i) (event_o.busy || event_o.clear) |-> (age_r == 20'(SYM_CYC * WIN_SYMS));
  endproperty
  a_verdict_time: assert property (p_verdict_time) else $error("assessment verdict at wrong time");

  property p_ed_thresh;
    @(posedge clk_i) disable iff (rst_i)
      ((event_o.busy || event_o.clear) && st_r.ctrl.cca_mode == lpp_pkg::LPP_CCA_ED) |-> (event_o.busy == (st_r.level >= st_r.thr));
  endproperty
  a_ed_thresh: assert property (p_ed_thresh) else $error("energy threshold verdict wrong");

  property p_carrier;
    @(posedge clk_i) disable iff (rst_i)
      (event_o.busy && st_r.ctrl.cca_mode == lpp_pkg::LPP_CCA_CARRIER) |-> ($past(st_r.cs_seen) || $past(rx_st_r) != lpp_pkg::LPP_RX_HUNT);
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier busy without delimiter");

  property p_ed_max;
    @(posedge clk_i) disable iff (rst_i) (event_o.ed_done && st_r.ed_cnt != 8'h00) |-> (st_r.level >= $past(st_r.maxv));
  endproperty
  a_ed_max: assert property (p_ed_max) else $error("scan maximum lost");

  property p_stop;
    @(posedge clk_i) disable iff (rst_i) (tsk[`LPP_TASK_ED_STOP] && ms_r == lpp_pkg::LPP_MS_ED) |=> (event_o.ed_halted && ms_r == lpp_pkg::LPP_MS_IDLE);
  endproperty
  a_stop: assert property (p_stop) else $error("scan stop not honoured");

endmodule
`default_nettype wire

// ### lpp_consts.svh
// offsets, reset values and timing figures of the low-rate pan phy block
`ifndef LPP_CONSTS_SVH
`define LPP_CONSTS_SVH

// register byte addresses
`define LPP_OFF_TASK 8'h00
`define LPP_OFF_CTRL 8'h04
`define LPP_OFF_SFD 8'h08
`define LPP_OFF_PTR 8'h0C
`define LPP_OFF_ENERGY_SCAN_REPEAT_COUNT 8'h10
`define LPP_OFF_THR 8'h14
`define LPP_OFF_LEVEL 8'h18
`define LPP_OFF_STATUS 8'h1C
`define LPP_OFF_FREQ 8'h20
`define LPP_OFF_SEED 8'h24

// task register bit positions
`define LPP_TASK_TX 0
`define LPP_TASK_ED_START 1
`define LPP_TASK_ED_STOP 2
`define LPP_TASK_CCA_START 3

// reset values
`define LPP_SFD_RST 8'hA7
`define LPP_SEED_RST 16'h0000

// framing
`define LPP_PRE_OCTETS 3'h4
`define LPP_PRE_VALUE 8'h00
`define LPP_FCS_OCTETS 8'h02
`define LPP_CRC_POLY 16'h8408

// timing
`define LPP_CLK_MHZ 100
`define LPP_SYM_US 16
`define LPP_SYM_CYC (`LPP_SYM_US * `LPP_CLK_MHZ)
`define LPP_WIN_SYMS 8

`endif

// ### lpp_pkg.sv
// types of the low-rate pan phy block
package lpp_pkg;

  typedef enum logic [3:0] {
    LPP_TX_IDLE, LPP_TX_PRE, LPP_TX_SFD, LPP_TX_FETCH, LPP_TX_WAIT, LPP_TX_LOAD, LPP_TX_PUSH, LPP_TX_CRC, LPP_TX_DONE
  } lpp_tx_st_t;

  typedef enum logic [1:0] {LPP_RX_HUNT, LPP_RX_PHR, LPP_RX_DATA} lpp_rx_st_t;

  typedef enum logic [1:0] {LPP_MS_IDLE, LPP_MS_ED, LPP_MS_CCA} lpp_ms_st_t;

  typedef enum logic [2:0] {LPP_CCA_ED, LPP_CCA_CARRIER, LPP_CCA_AND, LPP_CCA_OR, LPP_CCA_TEST1} lpp_cca_mode_t;

  typedef struct packed {
    logic [2:0] cca_mode;
    logic crc_en;
    logic phy_en;
  } lpp_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } lpp_bus_req_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } lpp_mem_req_t;

  typedef struct packed {
    logic frame_begin;
    logic frame_end;
    logic ed_done;
    logic ed_halted;
    logic busy;
    logic clear;
  } lpp_events_t;

  typedef struct packed {
    lpp_ctrl_t ctrl;
    logic [7:0] sfd;
    logic [15:0] ptr;
    logic [7:0] ed_cnt;
    logic [7:0] thr;
    logic [7:0] level;
    logic [15:0] seed;
    logic [6:0] freq;
    logic [31:0] rdata;
    logic crc_ok;
    logic [7:0] phr;
    logic [15:0] fcf;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [7:0] tx_hold;
    logic [6:0] tx_len;
    logic [7:0] tx_idx;
    logic [2:0] tx_cnt;
    logic [15:0] tx_crc;
    logic [6:0] rx_len;
    logic [7:0] rx_idx;
    logic [15:0] rx_crc;
    lpp_mem_req_t mem;
    lpp_events_t ev;
    logic [15:0] sym_cnt;
    logic [3:0] win_cnt;
    logic [10:0] acc;
    logic [7:0] maxv;
    logic [7:0] iter;
    logic [7:0] first;
    logic cs_seen;
  } lpp_state_t;

endpackage

// ### lpp_peer.sv
// peer radio model: stalling octet sink, octet and signal strength source
`timescale 1ns/1ps
`default_nettype none
module lpp_peer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // octets from the block
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ready_o,
  // octets and signal strength to the block
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic [7:0] rssi_o
);
  logic slow = 1'b1;
  logic [7:0] got [0:63];
  int n = 0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h3C;
    rssi_o = 8'h00;
  end
  // stalls every other cycle when slow
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
      if (tx_valid_i && tx_ready_o) begin
        got[n] <= tx_data_i;
        n <= n + 1;
      end
    end
  end
  task automatic send(input logic [7:0] b);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= b;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~b;
  endtask
  // delimiter, header, then exactly n data octets, n below 128
  task automatic send_frame(input logic [7:0] sfd, input logic [7:0] hdr, input logic [7:0] base);
    send(sfd);
    send(hdr);
    for (int i = 0; i < int'(hdr[6:0]); i++) begin
      send(base + 8'(i));
    end
  endtask
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the low-rate pan phy block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SYM = 8;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } lpp_tb_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  lpp_pkg::lpp_bus_req_t bus = '0;
  lpp_pkg::lpp_mem_req_t mem_req;
  lpp_pkg::lpp_events_t ev;
  logic [31:0] rdata;
  logic [31:0] r;
  logic [7:0] mem [0:255];
  logic [7:0] mem_rd = 8'h00;
  logic tx_valid, tx_ready, rx_valid;
  logic [7:0] tx_data, rx_data, rssi;
  logic [6:0] freq;
  int fails = 0;
  int cmp_count = 0;
  int fb_cnt = 0;
  int done_cnt = 0;
  int n, m;
  logic [7:0] txe [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h03, 8'h11, 8'h22, 8'h33};
  lpp_tb_row_t rows [9] = '{'{8'h08, 32'h5A, 32'h5A}, '{8'h0C, 32'h10, 32'h10}, '{8'h10, 32'h0, 32'h0},
    '{8'h14, 32'h20, 32'h20}, '{8'h20, 32'h5, 32'h5}, '{8'h24, 32'h0, 32'h0}, '{8'h20, 32'h50, 32'h50},
    '{8'h30, 32'hFF, 32'h0}, '{8'h18, 32'hFF, 32'h0}};
  always #5 clk_i = ~clk_i;
  lpp_phy #(.SYM_CYC(SYM), .WIN_SYMS(8)) lpp_phy_i (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus),
    .bus_rdata_o(rdata), .mem_o(mem_req), .mem_rdata_i(mem_rd), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .tx_ready_i(tx_ready), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rssi_i(rssi), .event_o(ev),
    .freq_setting_o(freq));
  lpp_peer lpp_peer_i (.clk_i(clk_i), .rst_i(rst_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rssi_o(rssi));
  // frame buffer memory and event counters
  always @(posedge clk_i) begin
    if (mem_req.re) mem_rd <= mem[mem_req.addr[7:0]];
    if (mem_req.we) mem[mem_req.addr[7:0]] <= mem_req.wdata;
    if (ev.frame_begin) fb_cnt <= fb_cnt + 1;
    if (ev.ed_done) done_cnt <= done_cnt + 1;
  end
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus.we <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk_i);
    bus.we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    bus.re <= 1'b1;
    bus.addr <= a;
    @(posedge clk_i);
    bus.re <= 1'b0;
    #1;
    r = rdata;
  endtask
  // bounded wait for any event in mask; n counts the edges
  task automatic wait_ev(input logic [5:0] mask, input int lim);
    n = 0;
    #1;
    while ((ev & mask) === 6'h00 && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if ((ev & mask) === 6'h00) begin
      fails++;
      $display("unexpected timeout: expected event %h, seen none", mask);
      stop_test();
    end
  endtask
  task automatic cca(input logic [2:0] md, input logic [7:0] lvl, input logic [7:0] lvl2, input logic sfd,
      input logic busy);
    wr(8'h04, {27'h0, md, 2'b01});
    lpp_peer_i.rssi_o <= lvl;
    wr(8'h00, 32'h8);
    fork
      wait_ev(6'h03, 200);
      begin
        repeat (12) @(posedge clk_i);
        lpp_peer_i.rssi_o <= lvl2;
        if (sfd) lpp_peer_i.send_frame(8'h5A, 8'h00, 8'h00);
      end
    join
    check("medium verdict", {30'h0, busy, !busy}, {30'h0, ev.busy, ev.clear});
    check("assessment time", 1, {31'h0, n >= 8 * SYM && n <= 8 * SYM + 2});
    rd(8'h18);
    check("assessed level", {24'h0, lvl}, r);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check("events in reset", 0, {26'h0, ev});
    rd(8'h08);
    check("delimiter reset", 32'hA7, r);
    for (int i = 0; i < 9; i++) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      check("register", rows[i].e, r);
    end
    check("frequency setting", 32'h50, {25'h0, freq});
    wr(8'h04, 32'h1);
    mem[8'h10] = 8'h03;
    mem[8'h11] = 8'h11;
    mem[8'h12] = 8'h22;
    mem[8'h13] = 8'h33;
    wr(8'h00, 32'h1);
    wait_ev(6'h10, 500);
    check("sent octets", 9, lpp_peer_i.n);
    for (int i = 0; i < 9; i++) begin
      check("sent octet", {24'h0, txe[i]}, {24'h0, lpp_peer_i.got[i]});
    end
    wr(8'h0C, 32'h40);
    mem[8'h43] = 8'hEE;
    m = fb_cnt;
    lpp_peer_i.send_frame(8'h5A, 8'h80, 8'h00);
    repeat (4) @(posedge clk_i);
    check("zero length frame start", m, fb_cnt);
    lpp_peer_i.send_frame(8'h5A, 8'h82, 8'hA0);
    repeat (4) @(posedge clk_i);
    check("frame start", m + 1, fb_cnt);
    check("stored header", 32'h82, {24'h0, mem[8'h40]});
    check("stored data", 32'hA0A1EE, {8'h0, mem[8'h41], mem[8'h42], mem[8'h43]});
    rd(8'h1C);
    check("reported header", 32'h82, {24'h0, r[15:8]});
    // checksum on: one data octet, fcs of it is 1189
    wr(8'h04, 32'h3);
    mem[8'h40] = 8'h03;
    mem[8'h41] = 8'h01;
    m = lpp_peer_i.n;
    wr(8'h00, 32'h1);
    wait_ev(6'h10, 500);
    check("sent octets with checksum", m + 9, lpp_peer_i.n);
    check("checksum octets", 32'h1189, {16'h0, lpp_peer_i.got[m + 8], lpp_peer_i.got[m + 7]});
    lpp_peer_i.send(8'h5A);
    lpp_peer_i.send(8'h03);
    lpp_peer_i.send(8'h01);
    lpp_peer_i.send(8'h89);
    lpp_peer_i.send(8'h11);
    repeat (4) @(posedge clk_i);
    check("checksum octet kept out", 32'h01A1, {16'h0, mem[8'h41], mem[8'h42]});
    rd(8'h1C);
    check("status after checked frame", 32'h89010301, r);
    lpp_peer_i.rssi_o <= 8'h27;
    wr(8'h00, 32'h2);
    wait_ev(6'h08, 200);
    check("scan time", 1, {31'h0, n >= 8 * SYM && n <= 8 * SYM + 2});
    rd(8'h18);
    check("scan level", 32'h27, r);
    wr(8'h10, 32'h3);
    for (int k = 0; k < 2; k++) begin
      lpp_peer_i.rssi_o <= k == 0 ? 8'h30 : 8'h10;
      m = done_cnt;
      wr(8'h00, 32'h2);
      repeat (100) @(posedge clk_i);
      lpp_peer_i.rssi_o <= 8'h10;
      wait_ev(6'h08, 300);
      repeat (80) @(posedge clk_i);
      check("scan done count", m + 1, done_cnt);
      rd(8'h18);
      check("scan maximum", k == 0 ? 32'h30 : 32'h10, r);
    end
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h2);
    wr(8'h00, 32'h4);
    wait_ev(6'h04, 4);
    m = done_cnt;
    repeat (80) @(posedge clk_i);
    check("done after stop", m, done_cnt);
    cca(3'h0, 8'h20, 8'h20, 1'b0, 1'b1);
    cca(3'h0, 8'h1F, 8'h1F, 1'b0, 1'b0);
    cca(3'h1, 8'h00, 8'h00, 1'b1, 1'b1);
    cca(3'h1, 8'h00, 8'h00, 1'b0, 1'b0);
    cca(3'h2, 8'h40, 8'h40, 1'b0, 1'b0);
    cca(3'h2, 8'h40, 8'h40, 1'b1, 1'b1);
    cca(3'h3, 8'h40, 8'h40, 1'b0, 1'b1);
    cca(3'h3, 8'h00, 8'h00, 1'b1, 1'b1);
    cca(3'h4, 8'h40, 8'h00, 1'b0, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
